/* cd_cfg_pkg.sv */
/*
 * Constants for the gain, chop and current-detect configuration slice:
 * register indices, field positions, reset values and code decoders.
 * Assumes a 32-bit APB bus where byte address = 4 * register index.
 */
package cd_cfg_pkg;

    // Register indices (byte address is four times the index)
    localparam logic [5:0] IDX_GAIN = 6'h04;
    localparam logic [5:0] IDX_RSVD5 = 6'h05;
    localparam logic [5:0] IDX_CFG = 6'h06;
    localparam logic [5:0] IDX_THR_HI = 6'h07;
    localparam logic [5:0] IDX_THR_LO = 6'h08;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
    localparam logic [5:0] IDX_IRQ_EN = 6'h11;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h12;
    localparam logic [5:0] IDX_DET_STAT = 6'h13;

    // Gain register fields
    localparam int GAIN_CH1_LSB = 4;
    localparam int GAIN_CH0_LSB = 0;
    localparam logic [2:0] GAIN_RST = 3'h0;

    // Configuration register fields and reset value
    localparam logic [15:0] CFG_RST = 16'h0600;
    localparam logic [15:0] CFG_MASK = 16'h1FFF;
    localparam int CFG_DLY_LSB = 9;
    localparam int CFG_CHOP_EN = 8;
    localparam int CFG_ALLCH = 7;
    localparam int CFG_NUM_LSB = 4;
    localparam int CFG_LEN_LSB = 1;
    localparam int CFG_DET_EN = 0;

    // Threshold registers
    localparam logic [15:0] THR_RST = 16'h0000;
    localparam logic [15:0] THR_LO_MASK = 16'hFF00;
    localparam int THR_LO_LSB = 8;

    // Interrupt bit positions
    localparam int IRQ_DETECT = 0;
    localparam int IRQ_CHOP_DONE = 1;
    localparam int IRQ_BITS = 2;

    // Exceedance count needed: 1, 2, 4 ... 128
    function automatic logic [7:0] exceed_needed(input logic [2:0] code);
        exceed_needed = 8'h01 << code;
    endfunction : exceed_needed

    // Measurement window length in conversion periods
    function automatic logic [11:0] window_periods(input logic [2:0] code);
        unique case (code)
            3'h0: window_periods = 12'h080;
            3'h1: window_periods = 12'h100;
            3'h2: window_periods = 12'h200;
            3'h3: window_periods = 12'h300;
            3'h4: window_periods = 12'h500;
            3'h5: window_periods = 12'h700;
            3'h6: window_periods = 12'hA00;
            3'h7: window_periods = 12'hE00;
        endcase
    endfunction : window_periods

    // Chop settling wait in modulator periods: 2 << code, 2 .. 65536
    function automatic logic [16:0] chop_delay_ticks(input logic [3:0] code);
        chop_delay_ticks = 17'h00002 << code;
    endfunction : chop_delay_ticks

endpackage : cd_cfg_pkg

/* exceed_counter.sv */
/*
 * Per-channel counter of conversion results whose magnitude exceeds
 * the detection threshold. Saturates at all ones.
 * Assumes sample_valid is a one-cycle strobe in the clk domain.
 */
`timescale 1ns/1ps
module exceed_counter #(
    parameter int DATA_W = 24,
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clear,
    input wire logic sample_valid,
    input wire logic [DATA_W-1:0] sample,
    input wire logic [DATA_W-1:0] threshold,
    output logic [CNT_W-1:0] count
);

    logic [DATA_W-1:0] magnitude;

    // Two's complement magnitude; the most negative value maps to 2^(W-1)
    assign magnitude = sample[DATA_W-1] ? (~sample + 1'b1) : sample;

    // Count exceedances, cleared at the start of each window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (ce) begin
            if (clear) begin
                count <= '0;
            end else if (sample_valid && (magnitude > threshold) && (count != '1)) begin
                count <= count + 1'b1;
            end
        end
    end

endmodule : exceed_counter

/* gain_chop_current_detect_config.sv */
/*
 * Configuration slice of a two-channel sigma-delta converter: per-channel
 * amplifier gain codes, global-chop enable with settling delay, and the
 * current-detect mode (enable, any/all rule, exceedance count, window
 * length, combined threshold), reached over APB, with a sticky interrupt.
 * Assumes conv_valid strobes once per conversion period with both channel
 * results, and mod_tick strobes once per modulator clock period.
 */
`timescale 1ns/1ps
module gain_chop_current_detect_config #(
    parameter int DATA_W = 24
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter side
    input wire logic mod_tick,
    input wire logic conv_valid,
    input wire logic [DATA_W-1:0] ch0_data,
    input wire logic [DATA_W-1:0] ch1_data,
    output logic [2:0] ch0_amp_gain_code,
    output logic [2:0] ch1_amp_gain_code,
    output logic chop_enable_bit,
    output logic chop_settling,
    output logic detect_out,
    output logic irq
);

    typedef enum logic [0:0] {DET_IDLE, DET_RUN} det_state_t;
    typedef enum logic [0:0] {CHOP_IDLE, CHOP_WAIT} chop_state_t;

    // Register storage
    logic [2:0] ch0_gain_r;
    logic [2:0] ch1_gain_r;
    logic [15:0] cfg_r;
    logic [15:0] thr_hi_r;
    logic [7:0] thr_lo_r;
    logic [cd_cfg_pkg::IRQ_BITS-1:0] irq_stat_r;
    logic [cd_cfg_pkg::IRQ_BITS-1:0] irq_stat_nxt;
    logic [cd_cfg_pkg::IRQ_BITS-1:0] irq_en_r;
    logic [cd_cfg_pkg::IRQ_BITS-1:0] irq_events;

    // APB handshake
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [31:0] rd_word;
    logic mapped;
    logic [5:0] idx;
    logic acc_done;
    logic wr_en;

    // Decoded configuration fields
    logic [3:0] detect_settle_code;
    logic [3:0] chop_settle_delay;
    logic detect_all_channels;
    logic [2:0] detect_exceed_count;
    logic [2:0] detect_window_length;
    logic detect_mode_enable;
    logic [DATA_W-1:0] threshold;

    // Current-detect machinery
    det_state_t det_state_r;
    logic [11:0] win_cnt_r;
    logic [7:0] cnt0;
    logic [7:0] cnt1;
    logic cnt_clear;
    logic count_en;
    logic win_end;
    logic hit;
    logic det_done_r;
    logic detect_r;

    // Chop settling machinery
    chop_state_t chop_state_r;
    logic [16:0] chop_cnt_r;
    logic chop_done;
    logic chop_settling_r;

    // Field extraction from the configuration word and threshold registers
    assign chop_settle_delay = cfg_r[cd_cfg_pkg::CFG_DLY_LSB +: 4];
    assign detect_settle_code = chop_settle_delay;
    assign detect_all_channels = cfg_r[cd_cfg_pkg::CFG_ALLCH];
    assign detect_exceed_count = cfg_r[cd_cfg_pkg::CFG_NUM_LSB +: 3];
    assign detect_window_length = cfg_r[cd_cfg_pkg::CFG_LEN_LSB +: 3];
    assign detect_mode_enable = cfg_r[cd_cfg_pkg::CFG_DET_EN];
    assign threshold = {thr_hi_r, thr_lo_r};

    // APB decode: word aligned, known index
    assign idx = paddr[7:2];
    assign acc_done = psel && penable && pready_r;
    assign wr_en = acc_done && pwrite && mapped;

    always_comb begin
        mapped = 1'b0;
        if (paddr[1:0] == 2'h0) begin
            unique case (idx)
                cd_cfg_pkg::IDX_GAIN, cd_cfg_pkg::IDX_RSVD5, cd_cfg_pkg::IDX_CFG,
                cd_cfg_pkg::IDX_THR_HI, cd_cfg_pkg::IDX_THR_LO,
                cd_cfg_pkg::IDX_IRQ_STAT, cd_cfg_pkg::IDX_IRQ_EN,
                cd_cfg_pkg::IDX_IRQ_CLR, cd_cfg_pkg::IDX_DET_STAT: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end

    // Read multiplexer; reserved bits and write-only words read zero
    always_comb begin
        rd_word = 32'h00000000;
        unique case (idx)
            cd_cfg_pkg::IDX_GAIN: begin
                rd_word[cd_cfg_pkg::GAIN_CH1_LSB +: 3] = ch1_gain_r;
                rd_word[cd_cfg_pkg::GAIN_CH0_LSB +: 3] = ch0_gain_r;
            end
            cd_cfg_pkg::IDX_CFG: rd_word[15:0] = cfg_r;
            cd_cfg_pkg::IDX_THR_HI: rd_word[15:0] = thr_hi_r;
            cd_cfg_pkg::IDX_THR_LO: rd_word[cd_cfg_pkg::THR_LO_LSB +: 8] = thr_lo_r;
            cd_cfg_pkg::IDX_IRQ_STAT: rd_word[cd_cfg_pkg::IRQ_BITS-1:0] = irq_stat_r;
            cd_cfg_pkg::IDX_IRQ_EN: rd_word[cd_cfg_pkg::IRQ_BITS-1:0] = irq_en_r;
            cd_cfg_pkg::IDX_DET_STAT: begin
                rd_word[0] = (det_state_r == DET_RUN);
                rd_word[1] = det_done_r;
                rd_word[2] = chop_settling_r;
                rd_word[15:8] = cnt0;
                rd_word[23:16] = cnt1;
            end
            default: rd_word = 32'h00000000;
        endcase
    end

    // APB answer: pready one cycle into the access phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r <= psel && penable && !pready_r;
            if (psel && penable && !pready_r) begin
                prdata_r <= (pwrite || !mapped) ? 32'h00000000 : rd_word; // Refused reads give 0
                pslverr_r <= !mapped;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // Gain register: only the two gain fields are stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ch0_gain_r <= cd_cfg_pkg::GAIN_RST;
            ch1_gain_r <= cd_cfg_pkg::GAIN_RST;
        end else if (ce && wr_en && idx == cd_cfg_pkg::IDX_GAIN) begin
            ch1_gain_r <= pwdata[cd_cfg_pkg::GAIN_CH1_LSB +: 3];
            ch0_gain_r <= pwdata[cd_cfg_pkg::GAIN_CH0_LSB +: 3];
        end
    end

    // Configuration and threshold words; reserved bits stay zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= cd_cfg_pkg::CFG_RST;
            thr_hi_r <= cd_cfg_pkg::THR_RST;
            thr_lo_r <= 8'h00;
        end else if (ce && wr_en) begin
            if (idx == cd_cfg_pkg::IDX_CFG) begin
                cfg_r <= pwdata[15:0] & cd_cfg_pkg::CFG_MASK;
            end
            if (idx == cd_cfg_pkg::IDX_THR_HI) begin
                thr_hi_r <= pwdata[15:0];
            end
            if (idx == cd_cfg_pkg::IDX_THR_LO) begin
                thr_lo_r <= pwdata[cd_cfg_pkg::THR_LO_LSB +: 8];
            end
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_en_r <= '0;
        end else if (ce && wr_en && idx == cd_cfg_pkg::IDX_IRQ_EN) begin
            irq_en_r <= pwdata[cd_cfg_pkg::IRQ_BITS-1:0];
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_comb begin
        irq_events = '0;
        irq_events[cd_cfg_pkg::IRQ_DETECT] = detect_r;
        irq_events[cd_cfg_pkg::IRQ_CHOP_DONE] = chop_done;
        irq_stat_nxt = irq_stat_r;
        if (wr_en && idx == cd_cfg_pkg::IDX_IRQ_CLR) begin
            irq_stat_nxt = irq_stat_r & ~pwdata[cd_cfg_pkg::IRQ_BITS-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_events;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            irq_stat_r <= irq_stat_nxt;
            irq <= |(irq_stat_nxt & irq_en_r);
        end
    end

    // Per-channel exceedance counters
    assign count_en = (det_state_r == DET_RUN) && conv_valid;
    assign win_end = count_en &&
        (win_cnt_r == cd_cfg_pkg::window_periods(detect_window_length) - 12'h001);
    assign cnt_clear = (det_state_r != DET_RUN) || win_end;

    exceed_counter #(.DATA_W(DATA_W), .CNT_W(8)) u_cnt0 (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .clear(cnt_clear),
        .sample_valid(count_en),
        .sample(ch0_data),
        .threshold(threshold),
        .count(cnt0)
    );

    exceed_counter #(.DATA_W(DATA_W), .CNT_W(8)) u_cnt1 (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .clear(cnt_clear),
        .sample_valid(count_en),
        .sample(ch1_data),
        .threshold(threshold),
        .count(cnt1)
    );

    // Detection condition under the any-channel or all-channels rule
    always_comb begin
        if (detect_all_channels) begin
            hit = (cnt0 >= cd_cfg_pkg::exceed_needed(detect_exceed_count)) &&
                  (cnt1 >= cd_cfg_pkg::exceed_needed(detect_exceed_count));
        end else begin
            hit = (cnt0 >= cd_cfg_pkg::exceed_needed(detect_exceed_count)) ||
                  (cnt1 >= cd_cfg_pkg::exceed_needed(detect_exceed_count));
        end
    end

    // Measurement window sequencer; one detection per window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            det_state_r <= DET_IDLE;
            win_cnt_r <= 12'h000;
            det_done_r <= 1'b0;
            detect_r <= 1'b0;
        end else if (ce) begin
            detect_r <= 1'b0;
            unique case (det_state_r)
                DET_IDLE: begin
                    win_cnt_r <= 12'h000;
                    det_done_r <= 1'b0;
                    if (detect_mode_enable) begin
                        det_state_r <= DET_RUN;
                    end
                end
                DET_RUN: begin
                    if (!detect_mode_enable) begin
                        det_state_r <= DET_IDLE;
                    end else if (win_end) begin
                        win_cnt_r <= 12'h000;
                        det_done_r <= 1'b0;
                    end else begin
                        if (count_en) begin
                            win_cnt_r <= win_cnt_r + 12'h001;
                        end
                        if (hit && !det_done_r) begin
                            detect_r <= 1'b1;
                            det_done_r <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Chop settling wait started by a conversion while chop is on and no wait is running
    assign chop_done = (chop_state_r == CHOP_WAIT) && mod_tick && (chop_cnt_r == 17'h00001);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chop_state_r <= CHOP_IDLE;
            chop_cnt_r <= 17'h00000;
            chop_settling_r <= 1'b0;
        end else if (ce) begin
            unique case (chop_state_r)
                CHOP_IDLE: begin
                    chop_settling_r <= 1'b0;
                    if (cfg_r[cd_cfg_pkg::CFG_CHOP_EN] && conv_valid) begin
                        chop_state_r <= CHOP_WAIT;
                        chop_cnt_r <= cd_cfg_pkg::chop_delay_ticks(detect_settle_code);
                        chop_settling_r <= 1'b1;
                    end
                end
                CHOP_WAIT: begin
                    if (!cfg_r[cd_cfg_pkg::CFG_CHOP_EN] || chop_done) begin
                        chop_state_r <= CHOP_IDLE;
                        chop_settling_r <= 1'b0;
                    end else if (mod_tick) begin
                        chop_cnt_r <= chop_cnt_r - 17'h00001;
                    end
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ch0_amp_gain_code <= cd_cfg_pkg::GAIN_RST;
            ch1_amp_gain_code <= cd_cfg_pkg::GAIN_RST;
            chop_enable_bit <= 1'b0;
            chop_settling <= 1'b0;
            detect_out <= 1'b0;
        end else if (ce) begin
            ch0_amp_gain_code <= ch0_gain_r;
            ch1_amp_gain_code <= ch1_gain_r;
            chop_enable_bit <= cfg_r[cd_cfg_pkg::CFG_CHOP_EN];
            chop_settling <= chop_settling_r;
            detect_out <= detect_r;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

endmodule : gain_chop_current_detect_config

/* cd_cfg_sva.sv */
/* Assertions for the gain, chop and detect configuration slice.
   Assumes ce stays high and sees only the top module's ports. */
`timescale 1ns/1ps
module cd_cfg_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] ch0_amp_gain_code,
    input wire logic [2:0] ch1_amp_gain_code,
    input wire logic chop_enable_bit,
    input wire logic detect_out
);
    logic [31:0] wd_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Write data captured at the completing edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wd_r <= 32'h0;
        end else if (pready) begin
            wd_r <= pwdata;
        end
    end

    // Setup cycle then first access cycle
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    // Accepted write to one address
    sequence s_wr(a);
        pready && pwrite && !pslverr && paddr == a;
    endsequence

    a_access_two_cycles: assert property (s_access |=> pready)
        else $error("pready not in second access cycle");
    a_pready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ch1_gain_follows: assert property (s_wr(8'h10) |=> ##1 ch1_amp_gain_code == wd_r[6:4])
        else $error("ch1 gain code not updated");
    a_ch0_gain_follows: assert property (s_wr(8'h10) |=> ##1 ch0_amp_gain_code == wd_r[2:0])
        else $error("ch0 gain code not updated");
    a_chop_bit_follows: assert property (s_wr(8'h18) |=> ##1 chop_enable_bit == wd_r[8])
        else $error("chop enable not updated");
    a_unaligned_refused: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access accepted");
    a_error_data_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("read data not zero on error");
    a_rsvd_word_zero: assert property (pready && !pwrite && paddr == 8'h14 |-> prdata == 32'h0)
        else $error("reserved word reads nonzero");
    a_cfg_upper_zero: assert property (pready && !pwrite && paddr == 8'h18 |-> prdata[31:13] == 19'h0)
        else $error("cfg reserved bits read nonzero");
    a_detect_one_pulse: assert property (detect_out |=> !detect_out)
        else $error("detect pulse longer than one cycle");
endmodule : cd_cfg_sva

bind gain_chop_current_detect_config cd_cfg_sva u_sva (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch0_amp_gain_code(ch0_amp_gain_code),
    .ch1_amp_gain_code(ch1_amp_gain_code), .chop_enable_bit(chop_enable_bit),
    .detect_out(detect_out));

/* tb.sv */
/* Self-checking bench for the configuration slice.
   Drives APB and converter strobes; ce is held high throughout. */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat, v;
    logic pready, pslverr, rerr, chop_enable_bit, chop_settling, detect_out, irq;
    logic mod_tick = 1'b0, conv_valid = 1'b0;
    logic [23:0] ch0_data = 24'h0, ch1_data = 24'h0;
    logic [2:0] ch0_amp_gain_code, ch1_amp_gain_code, c1, c0;
    int miscompares = 0, total_checks = 0, cycles = 0, det_cnt = 0;
    int seed = 32'h9601;

    gain_chop_current_detect_config #(.DATA_W(24)) u_gain_chop_current_detect_config (
        .clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mod_tick(mod_tick), .conv_valid(conv_valid), .ch0_data(ch0_data),
        .ch1_data(ch1_data), .ch0_amp_gain_code(ch0_amp_gain_code),
        .ch1_amp_gain_code(ch1_amp_gain_code), .chop_enable_bit(chop_enable_bit),
        .chop_settling(chop_settling), .detect_out(detect_out), .irq(irq));

    always #5 clk = ~clk;

    // Cycle ceiling and detection pulse counter
    always @(posedge clk) begin
        cycles++;
        if (detect_out === 1'b1) det_cnt++;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end

    function automatic logic [31:0] gain_word(input logic [2:0] g1, input logic [2:0] g0);
        gain_word = {25'h0, g1, 1'b0, g0};
    endfunction : gain_word

    function automatic logic [31:0] cfg_word(input logic [3:0] dly, input logic gc,
        input logic all, input logic [2:0] num, input logic [2:0] len, input logic en);
        cfg_word = {19'h0, dly, gc, all, num, len, en};
    endfunction : cfg_word

    task automatic conclude();
        $display("Checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait states end only by pready or by the bench ceiling
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp,
        input logic err);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rdat);
        chk("pslverr", {31'h0, err}, {31'h0, rerr});
    endtask : rdc

    // One conversion strobe, then time for the result to settle
    task automatic conv(input logic [23:0] a, input logic [23:0] b);
        @(posedge clk);
        conv_valid <= 1'b1;
        ch0_data <= a;
        ch1_data <= b;
        @(posedge clk);
        conv_valid <= 1'b0;
        ch0_data <= ~a;
        ch1_data <= ~b;
        repeat (6) @(posedge clk);
    endtask : conv

    task automatic tick();
        @(posedge clk);
        mod_tick <= 1'b1;
        @(posedge clk);
        mod_tick <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : tick

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        // Reset values and refused addresses
        rdc("gain", 8'h10, 32'h0, 1'b0);
        rdc("rsvd", 8'h14, 32'h0, 1'b0);
        rdc("cfg", 8'h18, 32'h600, 1'b0);
        rdc("thr hi", 8'h1C, 32'h0, 1'b0);
        rdc("thr lo", 8'h20, 32'h0, 1'b0);
        rdc("unmapped", 8'h3C, 32'h0, 1'b1);
        rdc("unaligned", 8'h11, 32'h0, 1'b1);
        wr(8'h14, 32'h0);
        rdc("rsvd", 8'h14, 32'h0, 1'b0);
        // Every gain code on both channels
        for (int i = 0; i < 8; i++) begin
            c1 = i[2:0];
            c0 = i[2:0] ^ 3'h5;
            wr(8'h10, gain_word(c1, c0));
            repeat (2) @(posedge clk);
            chk("ch1 gain", {29'h0, c1}, {29'h0, ch1_amp_gain_code});
            chk("ch0 gain", {29'h0, c0}, {29'h0, ch0_amp_gain_code});
            rdc("gain", 8'h10, gain_word(c1, c0), 1'b0);
        end
        rdc("unaligned", 8'h12, 32'h0, 1'b1);
        // Every count and window code, random chop delays
        for (int i = 0; i < 8; i++) begin
            v = cfg_word(4'($random(seed)), i[0], i[1], i[2:0], 3'(7 - i), 1'b0);
            wr(8'h18, v);
            repeat (2) @(posedge clk);
            chk("chop en", {31'h0, v[8]}, {31'h0, chop_enable_bit});
            rdc("cfg", 8'h18, v, 1'b0);
        end
        v = 32'($random(seed)) & 32'h0000FFFF;
        wr(8'h1C, v);
        rdc("thr hi", 8'h1C, v, 1'b0);
        v = 32'($random(seed)) & 32'h0000FF00;
        wr(8'h20, v);
        rdc("thr lo", 8'h20, v, 1'b0);
        // Any channel, two exceedances over 0x000100, equal value not counted
        wr(8'h1C, 32'h1);
        wr(8'h20, 32'h0);
        wr(8'h44, 32'h1);
        wr(8'h18, cfg_word(4'h3, 1'b0, 1'b0, 3'h1, 3'h0, 1'b1));
        conv(24'h000100, 24'h0);
        conv(24'hFFFEFF, 24'h0);
        chk("detections", 32'h0, 32'(det_cnt));
        conv(24'h000101, 24'h0);
        chk("detections", 32'h1, 32'(det_cnt));
        chk("irq", 32'h1, {31'h0, irq});
        rdc("status", 8'h40, 32'h1, 1'b0);
        wr(8'h48, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        // All channels, interrupt masked
        wr(8'h44, 32'h0);
        wr(8'h18, 32'h0);
        wr(8'h18, cfg_word(4'h3, 1'b0, 1'b1, 3'h0, 3'h0, 1'b1));
        conv(24'h000200, 24'h0);
        chk("detections", 32'h1, 32'(det_cnt));
        conv(24'hFFFE00, 24'h000200);
        chk("detections", 32'h2, 32'(det_cnt));
        chk("irq", 32'h0, {31'h0, irq});
        // One detection per window; the window's last sample only restarts it
        conv(24'h000200, 24'h000200);
        chk("detections", 32'h2, 32'(det_cnt));
        repeat (124) conv(24'h0, 24'h0);
        conv(24'h000200, 24'h000200);
        chk("detections", 32'h2, 32'(det_cnt));
        conv(24'h000200, 24'h000200);
        chk("detections", 32'h3, 32'(det_cnt));
        rdc("det stat", 8'h4C, 32'h00010103, 1'b0);
        rdc("status", 8'h40, 32'h1, 1'b0);
        wr(8'h48, 32'h1);
        rdc("status", 8'h40, 32'h0, 1'b0);
        // Chop settling of two modulator ticks
        wr(8'h18, cfg_word(4'h0, 1'b1, 1'b0, 3'h0, 3'h0, 1'b0));
        conv(24'h0, 24'h0);
        chk("settling", 32'h1, {31'h0, chop_settling});
        tick();
        chk("settling", 32'h1, {31'h0, chop_settling});
        tick();
        chk("settling", 32'h0, {31'h0, chop_settling});
        rdc("status", 8'h40, 32'h2, 1'b0);
        conclude();
    end
endmodule : tb
